// file: hw/rcg_pkg.sv
/*
   Constants and carrier types for the receive guard and CRC/parity checker.
   Assumes a single 250 MHz clock and word-aligned AHB-Lite register access.
*/
package rcg_pkg;

   // ----------------------------------------------------------------
   // Register map (index, byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0]  IDX_GUARD  = 8'h11;
   localparam logic [7:0]  IDX_CRC    = 8'h12;
   localparam logic [7:0]  IDX_STATUS = 8'h20;
   localparam logic [7:0]  IDX_CTRL   = 8'h21;

   localparam logic [31:0] GUARD_RST  = 32'h0000_0000;
   localparam logic [31:0] CRC_RST    = 32'h0000_0000;
   localparam logic        CTRL_RST   = 1'b0;
   localparam logic [31:0] GUARD_MASK = 32'h0FFF_FFFF;
   localparam logic [31:0] CRC_MASK   = 32'hFFFF_0FFF;
   localparam logic [2:0]  HSIZE_WORD = 3'h2;

   // ----------------------------------------------------------------
   // CRC presets, residues and polynomials (LSB first)
   // ----------------------------------------------------------------
   localparam logic [2:0]  SEL_JIS    = 3'h0;
   localparam logic [2:0]  SEL_A      = 3'h1;
   localparam logic [2:0]  SEL_B      = 3'h3;
   localparam logic [2:0]  SEL_ARB    = 3'h7;
   localparam logic [15:0] PRESET_0   = 16'h0000;
   localparam logic [15:0] PRESET_1   = 16'h6363;
   localparam logic [15:0] PRESET_2   = 16'hA671;
   localparam logic [15:0] PRESET_3   = 16'hFFFF;
   localparam logic [15:0] PRESET_4   = 16'h0012;
   localparam logic [15:0] PRESET_5   = 16'hE012;
   localparam logic [15:0] RESIDUE    = 16'h0000;
   localparam logic [15:0] RESIDUE_INV = 16'hF0B8;
   localparam logic [15:0] CRC16_POLY = 16'h8408;
   localparam logic [4:0]  CRC5_POLY  = 5'h14;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {MD_A, MD_B, MD_JIS212, MD_JIS424} rcg_proto_t;

   typedef struct packed {
      logic [3:0]  rsvd;
      logic [19:0] wait_val;
      logic [7:0]  presc;
   } rcg_guard_cfg_t;

   typedef struct packed {
      logic [15:0] preset;
      logic [3:0]  rsvd;
      logic        par_odd;
      logic        par_en;
      logic        coll_keep;
      logic [2:0]  first_bit_position_alias;
      logic [2:0]  sel;
      logic        crc5;
      logic        crc_inverted_compare;
      logic        crc_en;
   } rcg_crc_cfg_t;

   typedef struct packed {
      logic valid;
      logic data;
      logic coll;
   } rcg_rxbit_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic [2:0] nbits;
      logic       par_err;
   } rcg_rxbyte_t;

endpackage : rcg_pkg

// file: hw/rcg_top.sv
/*
   Receive guard timer, CRC/parity checking decoder and mode-detector
   overrides, with an AHB-Lite register slave.
   Assumes all inputs synchronous to clock, one-cycle event pulses and
   a demodulator that delivers one bit per rx_bit.valid.
*/
module rcg_top (
   input  wire logic               clock,
   input  wire logic               rst,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic                    hresp,
   output logic [31:0]             hrdata,
   input  wire logic               tx_end,
   input  wire logic               rx_start,
   input  wire logic               rx_end,
   input  wire rcg_pkg::rcg_rxbit_t rx_bit,
   input  wire logic               md_valid,
   input  wire rcg_pkg::rcg_proto_t md_proto,
   output rcg_pkg::rcg_rxbyte_t    rx_byte,
   output logic                    guard_active,
   output logic                    integrity_err
);
   import rcg_pkg::*;

   typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PAR} rcg_rx_state_t;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic b,
                                            input logic five);
      logic       fb;
      logic [4:0] c5;
      fb = c[0] ^ b;
      c5 = {1'b0, c[4:1]} ^ (fb ? CRC5_POLY : 5'h00);
      if (five) begin
         crc_step = {11'h000, c5};
      end else begin
         crc_step = {1'b0, c[15:1]} ^ (fb ? CRC16_POLY : 16'h0000);
      end
   endfunction : crc_step

   function automatic logic [15:0] sel_preset(input logic [2:0] s,
                                              input logic [15:0] arb);
      case (s)
         3'h0:    sel_preset = PRESET_0;
         3'h1:    sel_preset = PRESET_1;
         3'h2:    sel_preset = PRESET_2;
         3'h3:    sel_preset = PRESET_3;
         3'h4:    sel_preset = PRESET_4;
         3'h5:    sel_preset = PRESET_5;
         3'h7:    sel_preset = arb;
         default: sel_preset = PRESET_0;
      endcase
   endfunction : sel_preset

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [31:0]    guard_q;
   logic [31:0]    crccfg_q;
   logic           auto_q;
   logic           dph_q;
   logic           dwr_q;
   logic [7:0]     didx_q;
   logic           dok_q;
   logic           guard_q_on;
   logic [19:0]    gtimer_q;
   logic [7:0]     pcnt_q;
   rcg_rx_state_t  st_q;
   logic [7:0]     shreg_q;
   logic [2:0]     idx_q;
   logic           coll_q;
   logic [15:0]    crc_q;
   logic           ierr_q;
   rcg_rxbyte_t    byte_q;
   rcg_guard_cfg_t gcfg;
   rcg_crc_cfg_t   ccfg;
   logic           aph;
   logic           amap;
   logic           wr_guard;
   logic           wr_crc;
   logic           wr_ctrl;
   logic           start_ok;
   logic           bit_ok;
   logic           eff_bit;
   logic [7:0]     byte_d;
   logic           par_bad;
   logic           crc_bad;
   logic           end_ok;
   logic [15:0]    seed;

   assign gcfg = rcg_guard_cfg_t'(guard_q);
   assign ccfg = rcg_crc_cfg_t'(crccfg_q);
   assign seed = sel_preset(ccfg.sel, ccfg.preset);

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------
   // Zero wait states; read data is a mux of flops in the data phase so
   // a read right after a write to the same word sees the new value.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign aph       = hsel && htrans[1] && hready;
   assign amap      = (haddr[31:10] == 22'h000000) && (hsize == HSIZE_WORD)
                      && (haddr[1:0] == 2'h0);
   assign wr_guard  = dph_q && dwr_q && dok_q && (didx_q == IDX_GUARD);
   assign wr_crc    = dph_q && dwr_q && dok_q && (didx_q == IDX_CRC);
   assign wr_ctrl   = dph_q && dwr_q && dok_q && (didx_q == IDX_CTRL);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dph_q  <= 1'b0;
         dwr_q  <= 1'b0;
         didx_q <= 8'h00;
         dok_q  <= 1'b0;
      end else if (hready) begin
         dph_q  <= aph;
         dwr_q  <= hwrite;
         didx_q <= haddr[9:2];
         dok_q  <= amap;
      end
   end

   always_comb begin
      hrdata = 32'h0000_0000;
      if (dph_q && !dwr_q && dok_q) begin
         case (didx_q)
            IDX_GUARD:  hrdata = guard_q;
            IDX_CRC:    hrdata = crccfg_q;
            IDX_STATUS: hrdata = {29'h0000_0000, (st_q != RX_IDLE),
                                  guard_q_on, ierr_q};
            IDX_CTRL:   hrdata = {31'h0000_0000, auto_q};
            default:    hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         guard_q <= GUARD_RST;
         auto_q  <= CTRL_RST;
      end else begin
         if (wr_guard) begin
            guard_q <= hwdata & GUARD_MASK;
         end
         if (wr_ctrl) begin
            auto_q <= hwdata[0];
         end
      end
   end

   // ----------------------------------------------------------------
   // CRC/parity config with mode detector overrides
   // ----------------------------------------------------------------
   // The detector wins over a bus write in the same cycle, as it
   // reflects the traffic actually on the air.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         crccfg_q <= CRC_RST;
      end else if (md_valid && auto_q) begin
         if (wr_crc) begin
            crccfg_q <= hwdata & CRC_MASK;
         end
         case (md_proto)
            MD_A: begin
               crccfg_q[11]  <= 1'b1;
               crccfg_q[10]  <= 1'b1;
               crccfg_q[5:3] <= SEL_A;
               crccfg_q[1]   <= 1'b0;
            end
            MD_B: begin
               crccfg_q[5:3] <= SEL_B;
               crccfg_q[1]   <= 1'b1;
               crccfg_q[0]   <= 1'b1;
            end
            default: begin
               crccfg_q[5:3] <= SEL_JIS;
               crccfg_q[1]   <= 1'b0;
               crccfg_q[0]   <= 1'b1;
            end
         endcase
      end else if (wr_crc) begin
         crccfg_q <= hwdata & CRC_MASK;
      end
   end

   // ----------------------------------------------------------------
   // Guard timer
   // ----------------------------------------------------------------
   // Guard time is wait_val periods of presc+1 clocks after tx_end.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         guard_q_on <= 1'b0;
         gtimer_q   <= 20'h00000;
         pcnt_q     <= 8'h00;
      end else if (tx_end) begin
         guard_q_on <= (gcfg.wait_val != 20'h00000);
         gtimer_q   <= gcfg.wait_val;
         pcnt_q     <= gcfg.presc;
      end else if (guard_q_on) begin
         if (pcnt_q == 8'h00) begin
            pcnt_q <= gcfg.presc;
            if (gtimer_q == 20'h00001) begin
               guard_q_on <= 1'b0;
            end
            gtimer_q <= gtimer_q - 20'h00001;
         end else begin
            pcnt_q <= pcnt_q - 8'h01;
         end
      end
   end
   assign guard_active = guard_q_on;

   // ----------------------------------------------------------------
   // Receive decoder
   // ----------------------------------------------------------------
   assign start_ok = rx_start && !guard_q_on;
   assign bit_ok   = rx_bit.valid && (st_q != RX_IDLE) && !rx_start;
   assign end_ok   = rx_end && (st_q != RX_IDLE) && !rx_start;
   assign eff_bit  = ((coll_q || rx_bit.coll) && !ccfg.coll_keep)
                     ? 1'b0 : rx_bit.data;
   always_comb begin
      byte_d         = shreg_q;
      byte_d[idx_q]  = eff_bit;
   end
   assign par_bad  = (^shreg_q ^ ccfg.par_odd) != rx_bit.data;
   assign crc_bad  = ccfg.crc_en && (crc_q != ((ccfg.crc_inverted_compare
                     && !ccfg.crc5) ? RESIDUE_INV : RESIDUE));

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q    <= RX_IDLE;
         shreg_q <= 8'h00;
         idx_q   <= 3'h0;
         coll_q  <= 1'b0;
      end else if (start_ok) begin
         st_q    <= RX_DATA;
         shreg_q <= 8'h00;
         idx_q   <= ccfg.first_bit_position_alias;
         coll_q  <= 1'b0;
      end else if (end_ok) begin
         st_q <= RX_IDLE;
      end else if (bit_ok) begin
         case (st_q)
            RX_DATA: begin
               coll_q <= coll_q || rx_bit.coll;
               if (idx_q == 3'h7) begin
                  shreg_q <= ccfg.par_en ? byte_d : 8'h00;
                  st_q    <= ccfg.par_en ? RX_PAR : RX_DATA;
                  idx_q   <= 3'h0;
               end else begin
                  shreg_q <= byte_d;
                  idx_q   <= idx_q + 3'h1;
               end
            end
            RX_PAR: begin
               st_q    <= RX_DATA;
               shreg_q <= 8'h00;
            end
            default: st_q <= RX_IDLE;
         endcase
      end
   end

   // Parity bits stay out of the CRC; the check covers data and CRC bytes.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         crc_q <= 16'h0000;
      end else if (start_ok) begin
         crc_q <= ccfg.crc5 ? {8'h00, seed[7:0]} : seed;
      end else if (bit_ok && (st_q == RX_DATA)) begin
         crc_q <= crc_step(crc_q, eff_bit, ccfg.crc5);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         byte_q <= '0;
      end else if (bit_ok && (st_q == RX_DATA) && (idx_q == 3'h7)
                   && !ccfg.par_en) begin
         byte_q <= '{valid: 1'b1, data: byte_d, nbits: 3'h0,
                     par_err: 1'b0};
      end else if (bit_ok && (st_q == RX_PAR)) begin
         byte_q <= '{valid: 1'b1, data: shreg_q, nbits: 3'h0,
                     par_err: par_bad};
      end else if (end_ok && (st_q == RX_DATA) && (idx_q != 3'h0)) begin
         byte_q <= '{valid: 1'b1, data: shreg_q, nbits: idx_q,
                     par_err: 1'b0};
      end else begin
         byte_q.valid   <= 1'b0;
         byte_q.par_err <= 1'b0;
      end
   end
   assign rx_byte = byte_q;

   // Set wins over the clear at the start of a new reception.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ierr_q <= 1'b0;
      end else if ((bit_ok && (st_q == RX_PAR) && par_bad)
                   || (end_ok && crc_bad)) begin
         ierr_q <= 1'b1;
      end else if (start_ok) begin
         ierr_q <= 1'b0;
      end
   end
   assign integrity_err = ierr_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_GUARD_OFF: assert property (@(posedge clock) disable iff (rst)
      tx_end && (gcfg.wait_val == 20'h00000) |=> !guard_active)
      else $error("guard ran with zero wait value");
   AST_GUARD_LOAD: assert property (@(posedge clock) disable iff (rst)
      tx_end && (gcfg.wait_val != 20'h00000)
      |=> guard_active && (gtimer_q == $past(gcfg.wait_val)))
      else $error("guard timer not loaded from wait value");
   AST_PRESC_HOLD: assert property (@(posedge clock) disable iff (rst)
      guard_active && !tx_end && (pcnt_q == 8'h02) && !wr_guard
      |=> $stable(gtimer_q) ##1 $stable(gtimer_q) ##1
          (pcnt_q == gcfg.presc) && (gtimer_q == $past(gtimer_q) - 20'h1))
      else $error("guard timer not paced by prescaler");
   AST_RX_BLOCK: assert property (@(posedge clock) disable iff (rst)
      guard_active && (st_q == RX_IDLE) |=> (st_q == RX_IDLE))
      else $error("reception started during guard time");
   AST_PAR_FLAG: assert property (@(posedge clock) disable iff (rst)
      rx_byte.valid && rx_byte.par_err |-> integrity_err)
      else $error("parity error not flagged");
   AST_PAR_CONT: assert property (@(posedge clock) disable iff (rst)
      bit_ok && (st_q == RX_PAR) && !rx_end |=> (st_q == RX_DATA))
      else $error("reception stopped after parity bit");
   AST_SEED_A: assert property (@(posedge clock) disable iff (rst)
      start_ok && (ccfg.sel == SEL_A) && !ccfg.crc5 |=> crc_q == PRESET_1)
      else $error("type A preset not loaded");
   AST_SEED5: assert property (@(posedge clock) disable iff (rst)
      start_ok && ccfg.crc5 |=> crc_q[15:8] == 8'h00)
      else $error("5-bit CRC seeded above low byte");
   AST_MD_A: assert property (@(posedge clock) disable iff (rst)
      md_valid && auto_q && (md_proto == MD_A)
      |=> ccfg.par_en && ccfg.par_odd && (ccfg.sel == SEL_A))
      else $error("type A detection did not set parity");
   AST_MD_B: assert property (@(posedge clock) disable iff (rst)
      md_valid && auto_q && (md_proto == MD_B)
      |=> ccfg.crc_en && ccfg.crc_inverted_compare && (ccfg.sel == SEL_B))
      else $error("type B detection did not set CRC fields");
   AST_ERR_CLR: assert property (@(posedge clock) disable iff (rst)
      start_ok |=> !integrity_err)
      else $error("integrity flag not cleared at start");
   AST_ALIGN: assert property (@(posedge clock) disable iff (rst)
      start_ok |=> idx_q == $past(ccfg.first_bit_position_alias))
      else $error("first bit position not taken from alignment");

   COV_PAR_ERR: cover property (@(posedge clock) disable iff (rst)
      rx_byte.valid && rx_byte.par_err);
   COV_CRC_ERR: cover property (@(posedge clock) disable iff (rst)
      end_ok && crc_bad);
   COV_GUARD_END: cover property (@(posedge clock) disable iff (rst)
      guard_active ##1 !guard_active);
   COV_MD_B: cover property (@(posedge clock) disable iff (rst)
      md_valid && auto_q && (md_proto == MD_B));

endmodule : rcg_top

// file: bench/rcg_peer.sv
/*
   Card-side model: frames received bits toward the receive decoder.
   Assumes the bench calls send() from its own process, clock running.
*/
module rcg_peer (
   input  wire logic           clock,
   output logic                rx_start,
   output logic                rx_end,
   output rcg_pkg::rcg_rxbit_t rx_bit
);
   import rcg_pkg::*;
   // ----------------------------------------------------------------
   // Framing
   // ----------------------------------------------------------------
   initial begin
      rx_start = 1'b0;
      rx_end = 1'b0;
      rx_bit = '0;
   end
   // Idle gaps toggle the data line so a stale level never looks valid
   task automatic send(input logic [63:0] d, input logic [63:0] c,
                       input int n, input bit slow);
      @(posedge clock);
      rx_start <= 1'b1;
      @(posedge clock);
      rx_start <= 1'b0;
      for (int i = 0; i < n; i++) begin
         rx_bit <= '{1'b1, d[i], c[i]};
         @(posedge clock);
         if (slow) begin
            rx_bit <= '{1'b0, ~d[i], 1'b0};
            @(posedge clock);
         end
      end
      rx_bit <= '{1'b0, ~rx_bit.data, 1'b0};
      rx_end <= 1'b1;
      @(posedge clock);
      rx_end <= 1'b0;
   endtask : send
endmodule : rcg_peer

// file: bench/rx_crc_parity_guard_config_tb_top.sv
/*
   Self-checking bench for the receive guard and CRC/parity checker.
   Assumes rcg_top with a zero-wait AHB-Lite slave and the rcg_peer card.
*/
`define CHK(nm, ex, sn) \
   begin comparisons++; if ((sn) !== (ex)) begin num_errors++; \
   $display("BAD %s exp %h seen %h", nm, ex, sn); end end
module rx_crc_parity_guard_config_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rcg_pkg::*;
   localparam logic [31:0] A_GRD = {22'h0, IDX_GUARD, 2'h0};
   localparam logic [31:0] A_CRC = {22'h0, IDX_CRC, 2'h0};
   localparam logic [31:0] A_CTL = {22'h0, IDX_CTRL, 2'h0};
   localparam logic [31:0] A_STS = {22'h0, IDX_STATUS, 2'h0};
   logic        clock, rst, hsel, hwrite, hreadyout, hresp, tx_end;
   logic        md_valid, rx_start, rx_end, guard_active, integrity_err;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   rcg_proto_t  md_proto;
   rcg_rxbit_t  rx_bit;
   rcg_rxbyte_t rx_byte;
   int          num_errors, comparisons, fn, npe;
   logic [2:0]  nb;
   logic [63:0] fb;
   logic [7:0]  got[$];
   rcg_top rcg_top_i (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .tx_end(tx_end), .rx_start(rx_start),
      .rx_end(rx_end), .rx_bit(rx_bit), .md_valid(md_valid),
      .md_proto(md_proto), .rx_byte(rx_byte), .guard_active(guard_active),
      .integrity_err(integrity_err));
   rcg_peer rcg_peer_i (.clock(clock), .rx_start(rx_start),
      .rx_end(rx_end), .rx_bit(rx_bit));
   always #2 clock = ~clock;
   always @(posedge clock) begin
      if (rx_byte.valid === 1'b1) begin
         got.push_back(rx_byte.data);
         npe += int'(rx_byte.par_err);
         nb = rx_byte.nbits;
      end
   end
   // ----------------------------------------------------------------
   // Bus, framing and CRC helpers
   // ----------------------------------------------------------------
   task automatic ahb(input logic w, input logic [31:0] a,
                      input logic [31:0] wd);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic add(input logic [7:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         fb[fn] = v[i];
         fn++;
      end
   endtask : add
   function automatic logic [15:0] crc(input logic [15:0] s,
                                       input logic [15:0] p);
      logic [15:0] r;
      r = s;
      for (int i = 0; i < fn; i++) begin
         r = (r >> 1) ^ ((r[0] ^ fb[i]) ? p : 16'h0);
      end
      return r;
   endfunction : crc
   task automatic frame(input logic [31:0] cfg, input logic [63:0] co,
                        input bit slow, output logic err);
      ahb(1'b1, A_CRC, cfg);
      got.delete();
      npe = 0;
      rcg_peer_i.send(fb, co, fn, slow);
      repeat (3) @(posedge clock);
      err = integrity_err;
   endtask : frame
   task automatic pulse_tx;
      @(posedge clock);
      tx_end <= 1'b1;
      @(posedge clock);
      tx_end <= 1'b0;
   endtask : pulse_tx
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      ahb(1'b0, A_CRC, 32'h0);
      `CHK("crc reset", 32'h0, rd)
      ahb(1'b1, A_GRD, 32'hFFFF_FFFF);
      ahb(1'b0, A_GRD, 32'h0);
      `CHK("guard rw", 32'h0FFF_FFFF, rd)
      ahb(1'b1, A_CRC, 32'hFFFF_FFFF);
      ahb(1'b0, A_CRC, 32'h0);
      `CHK("crc rw", 32'hFFFF_0FFF, rd)
      ahb(1'b1, 32'h0000_0050, 32'h1234_5678);
      ahb(1'b0, 32'h0000_0050, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      `CHK("resp okay", 1'b0, hresp)
   endtask : t_regs
   task automatic t_guard;
      logic [19:0] w[3];
      logic [7:0]  p[3];
      int          ex[3];
      int          n;
      w = '{20'h3, 20'h0, 20'h1};
      p = '{8'h2, 8'h5, 8'h7F};
      ex = '{9, 0, 128};
      for (int k = 0; k < 3; k++) begin
         ahb(1'b1, A_GRD, {4'h0, w[k], p[k]});
         pulse_tx();
         n = 0;
         repeat (200) begin
            @(posedge clock);
            if (guard_active === 1'b1) n++;
         end
         `CHK("guard len", ex[k], n)
      end
      ahb(1'b1, A_GRD, 32'h0000_0302);
      fn = 0;
      add(8'h5A, 8);
      pulse_tx();
      ahb(1'b0, A_STS, 32'h0);
      `CHK("status", 32'h2, rd)
      got.delete();
      rcg_peer_i.send(fb, '0, fn, 1'b0);
      repeat (3) @(posedge clock);
      `CHK("guard mute", 0, got.size())
      ahb(1'b1, A_GRD, 32'h0);
   endtask : t_guard
   task automatic t_parity;
      logic        o, e;
      logic [31:0] v;
      for (int k = 0; k < 2; k++) begin
         o = k[0];
         fn = 0;
         add(8'hA5, 8);
         add({7'h0, o}, 1);
         add(8'h3C, 8);
         add({7'h0, ~o}, 1);
         add(8'h0F, 8);
         add({7'h0, o}, 1);
         frame({20'h0, o, 11'h400}, '0, o, e);
         `CHK("parity err", 1'b1, e)
         v = {8'(got.size()), got[0], got[1], got[2]};
         `CHK("parity data", 32'h03A53C0F, v)
         `CHK("parity flags", 1, npe)
         fn = 0;
         add(8'h81, 8);
         add({7'h0, o}, 1);
         frame({20'h0, o, 11'h400}, '0, 1'b0, e);
         `CHK("err cleared", 1'b0, e)
         `CHK("no flags", 0, npe)
      end
   endtask : t_parity
   task automatic t_align;
      logic e;
      fn = 0;
      add(8'h17, 5);
      frame(32'h0000_00C0, '0, 1'b0, e);
      `CHK("aligned", 16'h01B8, {8'(got.size()), got[0]})
      for (int k = 0; k < 2; k++) begin
         fn = 0;
         add(8'hFF, 8);
         frame(k ? 32'h200 : 32'h0, 64'h4, 1'b0, e);
         `CHK("after coll", k ? 8'hFF : 8'h03, got[0])
      end
   endtask : t_align
   task automatic t_crc;
      logic [15:0] pr[8];
      logic [15:0] c;
      logic        e;
      pr = '{16'h0, 16'h6363, 16'hA671, 16'hFFFF,
             16'h0012, 16'hE012, 16'h0, 16'h5A3C};
      for (int s = 0; s < 8; s++) begin
         if (s == 6) continue;
         fn = 0;
         add(8'h12, 8);
         add(8'h34, 8);
         c = crc(pr[s], 16'h8408);
         add(c[7:0], 8);
         add(c[15:8], 8);
         frame({16'h5A3C, 10'h0, 3'(s), 3'b001}, '0, s[0], e);
         `CHK("crc good", 1'b0, e)
      end
      fb[3] = ~fb[3];
      frame(32'h5A3C_0039, '0, 1'b0, e);
      `CHK("crc bad", 1'b1, e)
      fn = 0;
      add(8'h12, 8);
      c = ~crc(16'hFFFF, 16'h8408);
      add(c[7:0], 8);
      add(c[15:8], 8);
      frame(32'h0000_001B, '0, 1'b0, e);
      `CHK("inv good", 1'b0, e)
      frame(32'h0000_0019, '0, 1'b0, e);
      `CHK("inv off", 1'b1, e)
      fn = 0;
      add(8'h12, 8);
      c = crc(16'h001B, 16'h0014);
      add(c[7:0], 5);
      frame(32'hA51B_003D, '0, 1'b0, e);
      `CHK("crc5 good", 1'b0, e)
      `CHK("tail bits", 3'h5, nb)
      fb[0] = ~fb[0];
      frame(32'hA51B_003D, '0, 1'b0, e);
      `CHK("crc5 bad", 1'b1, e)
   endtask : t_crc
   task automatic t_detect;
      logic [31:0] ex[4];
      logic [31:0] x;
      ex = '{32'h0C08, 32'h001B, 32'h0001, 32'h0001};
      for (int p = 0; p < 5; p++) begin
         ahb(1'b1, A_CTL, {31'h0, p != 0});
         ahb(1'b1, A_CRC, 32'h003A);
         @(posedge clock);
         md_valid <= 1'b1;
         md_proto <= rcg_proto_t'(p == 0 ? 0 : p - 1);
         @(posedge clock);
         md_valid <= 1'b0;
         ahb(1'b0, A_CRC, 32'h0);
         x = (p == 0) ? 32'h3A : ex[p - 1];
         `CHK("detector", x, rd)
      end
   endtask : t_detect
   task automatic print_verdict;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      {hsel, hwrite, tx_end, md_valid, htrans, haddr, hwdata} = '0;
      hsize = HSIZE_WORD;
      md_proto = MD_A;
      {num_errors, comparisons, fn, npe, fb} = '0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      t_regs();
      t_guard();
      t_parity();
      t_align();
      t_crc();
      t_detect();
      print_verdict();
   end
   // All scenarios need under two thousand cycles; this leaves ample margin
   initial begin
      repeat (30000) @(posedge clock);
      num_errors++;
      print_verdict();
   end
endmodule : rx_crc_parity_guard_config_tb_top
